// ===== dds_defs.svh
`ifndef DDS_DEFS_SVH
`define DDS_DEFS_SVH

// Register select within one converter (low two address bits).
`define DDS_REG_CTRL 2'h0
`define DDS_REG_LOW 2'h1
`define DDS_REG_HIGH 2'h2

// Address bit that selects the converter.
`define DDS_ADDR_CONV_BIT 2

// Control register layout.
`define DDS_EN_BIT 7
`define DDS_MD_HI 4
`define DDS_MD_LO 3
`define DDS_DF_HI 2
`define DDS_DF_LO 0
`define DDS_CTRL_MASK 8'h9f

// Reset values.
`define DDS_CTRL_RST 8'h00
`define DDS_DATA_RST 8'h00
`define DDS_CODE_RST 12'h000
`define DDS_READ_ZERO 8'h00

`endif

// ===== dds_pkg.sv
`default_nettype none

package dds_pkg;

  typedef enum logic [1:0] {
    DDS_UPD_WRITE = 2'b00,
    DDS_UPD_T3 = 2'b01,
    DDS_UPD_T4 = 2'b10,
    DDS_UPD_T2 = 2'b11
  } dds_upd_mode_t;

  typedef enum logic [2:0] {
    DDS_FMT_H4 = 3'b000,
    DDS_FMT_H5 = 3'b001,
    DDS_FMT_H6 = 3'b010,
    DDS_FMT_H7 = 3'b011,
    DDS_FMT_H8 = 3'b100
  } dds_fmt_t;

endpackage

`default_nettype wire

// ===== dds_align_if.sv
`default_nettype none

interface dds_align_if;
  logic [7:0] hi;
  logic [7:0] lo;
  logic [2:0] fmt;
  logic [11:0] code;

  modport src (
    output hi,
    output lo,
    output fmt,
    input code
  );

  modport dst (
    input hi,
    input lo,
    input fmt,
    output code
  );
endinterface

`default_nettype wire

// ===== dds_align.sv
`include "dds_defs.svh"

`default_nettype none

module dds_align
  import dds_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Latched bytes in, aligned code out.
  dds_align_if.dst al
);

  logic [11:0] code;
  logic [11:0] next_code;

  // Formats 100 to 111 all take the left-justified layout.
  always_comb begin
    case (al.fmt)
      DDS_FMT_H4: next_code = {al.hi[3:0], al.lo};
      DDS_FMT_H5: next_code = {al.hi[4:0], al.lo[7:1]};
      DDS_FMT_H6: next_code = {al.hi[5:0], al.lo[7:2]};
      DDS_FMT_H7: next_code = {al.hi[6:0], al.lo[7:3]};
      default: next_code = {al.hi, al.lo[7:4]};
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      code <= `DDS_CODE_RST;
    end else begin
      code <= next_code;
    end
  end

  assign al.code = code;

endmodule

`default_nettype wire

// ===== dds_sched.sv
// Functional notes
// - Each converter takes a 12-bit unsigned code, 000 to fff, straight binary.
// - Each converter has its own enable; disabled means output undriven and powered down; here only conv_enable_o drops, conv_code_o stays driven.
// - Reading the low byte returns the last written value, not the latch.
// - Reading the high byte returns the high input latch contents.
// - Update mode 00 (default) loads latches on a high byte write.
// - In mode 00 a low byte write is held until the next high byte write.
// - Modes 01, 10, 11 hold both bytes until timer 3, 4 or 2 overflow.
// - The selected overflow copies both held bytes into the latches together.
// - Control bits 2:0 choose one of five data word alignments.
// - The second converter is an identical, independent copy of the first.
`include "dds_defs.svh"

`default_nettype none

module dds_sched
  import dds_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register write port.
  input wire logic wr_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  // Register read port, data one cycle after the strobe.
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Timer overflow pulses from logic on the same clock.
  input wire logic tmr2_ovf_i,
  input wire logic tmr3_ovf_i,
  input wire logic tmr4_ovf_i,
  // Converter outputs.
  output logic [1:0][11:0] conv_code_o,
  output logic [1:0] conv_enable_o
);

  localparam int NUM_CONV = 2;

  logic [7:0] ctrl [NUM_CONV];
  logic [7:0] low_pend [NUM_CONV];
  logic [7:0] high_pend [NUM_CONV];
  logic [7:0] hi_lat [NUM_CONV];
  logic [7:0] lo_lat [NUM_CONV];
  logic [7:0] rdata;
  logic [7:0] next_rdata;

  dds_align_if al_if [NUM_CONV] ();

  // Each converter keeps its own copy of every register and latch.
  for (genvar g = 0; g < NUM_CONV; g++) begin : g_conv
    logic sel;
    logic tick;
    dds_upd_mode_t mode;
    logic [7:0] next_ctrl;
    logic [7:0] next_low_pend;
    logic [7:0] next_high_pend;
    logic [7:0] next_hi_lat;
    logic [7:0] next_lo_lat;

    always_comb begin
      sel = wr_i && (addr_i[`DDS_ADDR_CONV_BIT] == 1'(g));
      mode = dds_upd_mode_t'(ctrl[g][`DDS_MD_HI:`DDS_MD_LO]);
      next_ctrl = ctrl[g];
      next_low_pend = low_pend[g];
      next_high_pend = high_pend[g];
      next_hi_lat = hi_lat[g];
      next_lo_lat = lo_lat[g];
      if (sel && addr_i[1:0] == `DDS_REG_CTRL) begin
        next_ctrl = wdata_i & `DDS_CTRL_MASK;
      end
      if (sel && addr_i[1:0] == `DDS_REG_LOW) begin
        next_low_pend = wdata_i;
      end
      if (sel && addr_i[1:0] == `DDS_REG_HIGH) begin
        next_high_pend = wdata_i;
      end
      // Only the overflow of the selected timer counts.
      case (mode)
        DDS_UPD_WRITE: tick = sel && addr_i[1:0] == `DDS_REG_HIGH;
        DDS_UPD_T3: tick = tmr3_ovf_i;
        DDS_UPD_T4: tick = tmr4_ovf_i;
        default: tick = tmr2_ovf_i;
      endcase
      // Both halves land together, so the output never shows a mixed word.
      if (tick) begin
        next_hi_lat = (mode == DDS_UPD_WRITE) ? wdata_i : high_pend[g];
        next_lo_lat = low_pend[g];
      end
    end

    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        ctrl[g] <= `DDS_CTRL_RST;
        low_pend[g] <= `DDS_DATA_RST;
        high_pend[g] <= `DDS_DATA_RST;
        hi_lat[g] <= `DDS_DATA_RST;
        lo_lat[g] <= `DDS_DATA_RST;
      end else begin
        ctrl[g] <= next_ctrl;
        low_pend[g] <= next_low_pend;
        high_pend[g] <= next_high_pend;
        hi_lat[g] <= next_hi_lat;
        lo_lat[g] <= next_lo_lat;
      end
    end

    assign al_if[g].hi = hi_lat[g];
    assign al_if[g].lo = lo_lat[g];
    assign al_if[g].fmt = ctrl[g][`DDS_DF_HI:`DDS_DF_LO];

    dds_align u_align (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .al(al_if[g])
    );

    // The code is straight binary; the analog stage scales it to the reference.
    assign conv_code_o[g] = al_if[g].code;
    assign conv_enable_o[g] = ctrl[g][`DDS_EN_BIT];
  end

  // Read data holds its last value between read strobes.
  always_comb begin
    next_rdata = rdata;
    if (rd_i) begin
      if (addr_i[1:0] == `DDS_REG_CTRL) begin
        next_rdata = ctrl[addr_i[`DDS_ADDR_CONV_BIT]];
      end else if (addr_i[1:0] == `DDS_REG_LOW) begin
        next_rdata = low_pend[addr_i[`DDS_ADDR_CONV_BIT]];
      end else if (addr_i[1:0] == `DDS_REG_HIGH) begin
        next_rdata = hi_lat[addr_i[`DDS_ADDR_CONV_BIT]];
      end else begin
        next_rdata = `DDS_READ_ZERO;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata <= `DDS_READ_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;

endmodule

`default_nettype wire

// ===== dds_sched_props.sv
`default_nettype none
module dds_sched_props (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic tmr2_ovf_i,
  input wire logic tmr3_ovf_i,
  input wire logic tmr4_ovf_i,
  input wire logic [1:0][11:0] conv_code_o,
  input wire logic [1:0] conv_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] md;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // The first converter's mode is mirrored so held writes can be told from loading ones.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i)
      md <= 2'h0;
    else if (wr_i && addr_i == 3'h0)
      md <= wdata_i[4:3];
  end
  a_en_first: assert property (wr_i && addr_i == 3'h0 |=> conv_enable_o[0] == $past(wdata_i[7]))
    else $error("enable 0 wrong");
  a_en_second: assert property (wr_i && addr_i == 3'h4 |=> conv_enable_o[1] == $past(wdata_i[7]))
    else $error("enable 1 wrong");
  a_rst_clear: assert property (disable iff (1'b0) rst_i |=> conv_code_o == 24'h0 && conv_enable_o == 2'h0)
    else $error("reset state wrong");
  a_low_held: assert property (wr_i && addr_i == 3'h1 && md == 2'h0 |-> ##2 $stable(conv_code_o[0]))
    else $error("low write moved code");
  a_tmr_select: assert property (md == 2'h1 && !tmr3_ovf_i && !wr_i |-> ##2 $stable(conv_code_o[0]))
    else $error("code moved without timer 3");
  a_high_latch: assert property (wr_i && addr_i == 3'h2 && md == 2'h0 ##1 !wr_i ##1 rd_i && addr_i == 3'h2
    |=> rdata_o == $past(wdata_i, 3)) else $error("high read wrong");
  a_low_read: assert property (wr_i && addr_i == 3'h1 ##1 !wr_i ##1 rd_i && addr_i == 3'h1
    |=> rdata_o == $past(wdata_i, 3)) else $error("low read wrong");
  a_low_second: assert property (wr_i && addr_i == 3'h5 ##1 !wr_i ##1 rd_i && addr_i == 3'h5
    |=> rdata_o == $past(wdata_i, 3)) else $error("low read 1 wrong");
endmodule
bind dds_sched dds_sched_props dds_sched_props_inst (.clk_sys_i, .rst_i, .wr_i, .addr_i, .wdata_i, .rd_i,
  .rdata_o, .tmr2_ovf_i, .tmr3_ovf_i, .tmr4_ovf_i, .conv_code_o, .conv_enable_o);
`default_nettype wire

// ===== dds_tmr_model.sv
`default_nettype none
module dds_tmr_model (
  // Clock and request.
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic [2:0] sel_i,
  // Overflow pulses.
  output logic tmr2_o,
  output logic tmr3_o,
  output logic tmr4_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One request for timer 2, 3 or 4 gives one single-cycle pulse, like a real overflow; other selects give none.
  always_ff @(posedge clk_sys_i) begin
    tmr2_o <= go_i && sel_i == 3'h2;
    tmr3_o <= go_i && sel_i == 3'h3;
    tmr4_o <= go_i && sel_i == 3'h4;
  end
endmodule
`default_nettype wire

// ===== dds_sched_tb.sv
`default_nettype none
module dds_sched_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic go = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [2:0] sel = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic tmr2, tmr3, tmr4;
  logic [1:0][11:0] conv_code_o;
  logic [1:0] conv_enable_o;
  logic [11:0] pc;
  int errors = 0;
  int checks = 0;
  int ts;
  // Format, high byte, low byte, expected code.
  logic [35:0] rows [5] = '{36'h00_0f_ff_fff, 36'h01_00_01_000, 36'h02_3a_c4_eb1, 36'h03_55_f8_abf,
    36'h04_81_70_817};
  always #4 clk_sys_i = ~clk_sys_i;
  dds_sched dds_sched_inst (.clk_sys_i, .rst_i, .wr_i, .addr_i, .wdata_i, .rd_i, .rdata_o, .tmr2_ovf_i(tmr2),
    .tmr3_ovf_i(tmr3), .tmr4_ovf_i(tmr4), .conv_code_o, .conv_enable_o);
  dds_tmr_model dds_tmr_model_inst (.clk_sys_i, .go_i(go), .sel_i(sel), .tmr2_o(tmr2), .tmr3_o(tmr3),
    .tmr4_o(tmr4));
  task automatic cmp_code(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: code %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 cmp_byte(rdata_o, e);
  endtask
  task automatic fire(input logic [2:0] t);
    @(posedge clk_sys_i);
    go <= 1'b1;
    sel <= t;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1 cmp_code(conv_code_o[0], 12'h000);
    cmp_byte({6'h00, conv_enable_o}, 8'h00);
    foreach (rows[i]) begin
      wr(3'h0, 8'h80 | rows[i][35:28]);
      wr(3'h1, rows[i][19:12]);
      wr(3'h2, rows[i][27:20]);
      @(posedge clk_sys_i);
      #1 cmp_code(conv_code_o[0], rows[i][11:0]);
    end
    wr(3'h1, 8'h0f);
    repeat (2) @(posedge clk_sys_i);
    #1 cmp_code(conv_code_o[0], 12'h817);
    rd(3'h1, 8'h0f);
    rd(3'h2, 8'h81);
    wr(3'h2, 8'hc3);
    rd(3'h2, 8'hc3);
    cmp_code(conv_code_o[0], 12'hc30);
    pc = 12'h30f;
    for (int m = 1; m < 4; m++) begin
      ts = (m == 1) ? 3 : (m == 2) ? 4 : 2;
      wr(3'h0, 8'h80 | 8'(m << 3));
      wr(3'h1, 8'(m));
      rd(3'h1, 8'(m));
      wr(3'h2, 8'h0a);
      rd(3'h2, (m == 1) ? 8'hc3 : 8'h0a);
      for (int t = 2; t < 5; t++) if (t != ts) fire(3'(t));
      cmp_code(conv_code_o[0], pc);
      fire(3'(ts));
      pc = 12'ha00 | 12'(m);
      cmp_code(conv_code_o[0], pc);
    end
    wr(3'h4, 8'h84);
    wr(3'h5, 8'h50);
    rd(3'h5, 8'h50);
    wr(3'h6, 8'h12);
    rd(3'h5, 8'h50);
    cmp_code(conv_code_o[1], 12'h125);
    cmp_code(conv_code_o[0], pc);
    wr(3'h0, 8'h00);
    #1 cmp_byte({6'h00, conv_enable_o}, 8'h02);
    rd(3'h3, 8'h00);
    wr(3'h4, 8'hff);
    rd(3'h4, 8'h9f);
    cmp_code(conv_code_o[1], 12'h125);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1 cmp_code(conv_code_o[1], 12'h000);
    cmp_byte({6'h00, conv_enable_o}, 8'h00);
    cmp_byte(rdata_o, 8'h00);
    rd(3'h6, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
